/* File: core/bsr_readout.sv */
// Purpose: read-holding-registers slave for breaker status table
// Assumes: byte stream already deframed; frame_end_i marks silence gap
// Notes: status and validity words built live from contact inputs
`default_nettype none
module bsr_readout
    import bsr_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  slave_addr_i,
    input  wire logic        rx_valid_i,
    input  wire logic [7:0]  rx_data_i,
    input  wire logic        frame_end_i,
    output logic             tx_valid_o,
    output logic      [7:0]  tx_data_o,
    input  wire logic        tx_ready_i,
    output logic             tx_last_o,
    input  wire logic        contacts_closed_i,
    input  wire logic        any_trip_flag_i,
    input  wire logic        fault_trip_flag_i,
    input  wire logic        spring_charged_i,
    input  wire logic        ready_to_close_i,
    input  wire logic        has_spring_i,
    input  wire logic        has_ready_contact_i,
    input  wire logic        variant_flag_i,
    input  wire logic        data_valid_i,
    input  wire logic        tbl_we_i,
    input  wire logic [6:0]  tbl_waddr_i,
    input  wire logic [15:0] tbl_wdata_i,
    output logic             busy_o
);
    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers for contact inputs
    logic [8:0] pin_s1_reg;
    logic [8:0] pin_s2_reg;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_s1_reg <= 9'h000;
            pin_s2_reg <= 9'h000;
        end else begin
            pin_s1_reg <= {data_valid_i, variant_flag_i, has_ready_contact_i,
                           has_spring_i, ready_to_close_i, spring_charged_i,
                           fault_trip_flag_i, any_trip_flag_i, contacts_closed_i};
            pin_s2_reg <= pin_s1_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // live status and validity words
    logic [15:0] status_word;
    logic [15:0] validity_word;
    always_comb begin
        status_word = BSR_RESET_WORD;
        status_word[BSR_BIT_CLOSED]  = pin_s2_reg[0];
        status_word[BSR_BIT_TRIP]    = pin_s2_reg[1];
        status_word[BSR_BIT_FAULT]   = pin_s2_reg[2];
        status_word[BSR_BIT_SPRING]  = pin_s2_reg[3] & pin_s2_reg[5];
        status_word[BSR_BIT_READY]   = pin_s2_reg[4] & pin_s2_reg[6];
        status_word[BSR_BIT_VARIANT] = pin_s2_reg[7];
        status_word[BSR_BIT_UNAVAIL] = ~pin_s2_reg[8];
        // a flag is valid only while data is available
        validity_word = pin_s2_reg[8] ? (BSR_STATUS_IMPL & 16'h7FFF) : BSR_RESET_WORD;
    end

    ////////////////////////////////////////////////////////////////////////
    // request parser and reply sequencer
    bsr_state_t  state_reg;
    logic [2:0]  body_cnt_reg;
    logic [15:0] start_reg;
    logic [15:0] count_reg;
    logic [15:0] crc_reg;
    logic [7:0]  crc_lo_reg;
    logic        func_ok_reg;
    logic [7:0]  func_reg;
    logic [7:0]  exc_reg;
    logic [2:0]  head_idx_reg;
    logic [7:0]  word_idx_reg;
    logic        half_reg;
    logic        crc_half_reg;
    logic [7:0]  lo_byte_reg;
    logic [15:0] rdata;
    logic [6:0]  raddr;
    logic [15:0] reg_addr;
    logic [15:0] cur_word;
    logic        tx_fire;

    assign tx_fire  = tx_valid_o & tx_ready_i;
    assign reg_addr = start_reg + {8'h00, word_idx_reg};
    // next word fetched while the low byte of this one goes out
    assign raddr    = 7'(reg_addr + {15'h0000, half_reg} - BSR_ADDR_VALIDITY);
    assign busy_o   = (state_reg == BSR_TX_HEAD) || (state_reg == BSR_TX_DATA)
                      || (state_reg == BSR_TX_CRC) || tx_valid_o;

    bsr_table_mem u_mem (
        .clk_i   (clk_i),
        .we_i    (tbl_we_i & (tbl_waddr_i > 7'h01)),
        .waddr_i (tbl_waddr_i),
        .wdata_i (tbl_wdata_i),
        .raddr_i (raddr),
        .rdata_o (rdata)
    );

    // first two words are live; rest from table memory
    always_comb begin
        unique case (reg_addr)
            BSR_ADDR_VALIDITY: cur_word = validity_word;
            BSR_ADDR_STATUS:   cur_word = status_word;
            default:           cur_word = rdata;
        endcase
    end

    function automatic logic [7:0] head_byte(input logic [2:0] idx,
                                             input logic [7:0] fn,
                                             input logic [7:0] ex,
                                             input logic [7:0] sa,
                                             input logic [15:0] cnt);
        unique case (idx)
            3'd0:    return sa;
            3'd1:    return (ex != 8'h00) ? (fn | BSR_EXC_FLAG) : fn;
            default: return (ex != 8'h00) ? ex : 8'(cnt << 1);
        endcase
    endfunction

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg    <= BSR_RX_ADDR;
            body_cnt_reg <= 3'd0;
            start_reg    <= BSR_RESET_WORD;
            count_reg    <= BSR_RESET_WORD;
            crc_reg      <= BSR_CRC_INIT;
            crc_lo_reg   <= 8'h00;
            func_ok_reg  <= 1'b0;
            func_reg     <= 8'h00;
            exc_reg      <= 8'h00;
            head_idx_reg <= 3'd0;
            word_idx_reg <= 8'h00;
            half_reg     <= 1'b0;
            crc_half_reg <= 1'b0;
            lo_byte_reg  <= 8'h00;
            tx_valid_o   <= 1'b0;
            tx_data_o    <= 8'h00;
            tx_last_o    <= 1'b0;
        end else begin
            unique case (state_reg)
                BSR_RX_ADDR: if (rx_valid_i) begin
                    crc_reg   <= bsr_crc_byte(BSR_CRC_INIT, rx_data_i);
                    state_reg <= (rx_data_i == slave_addr_i) ? BSR_RX_FUNC : BSR_RX_SKIP;
                end
                BSR_RX_FUNC: if (rx_valid_i) begin
                    crc_reg      <= bsr_crc_byte(crc_reg, rx_data_i);
                    func_reg     <= rx_data_i;
                    // write functions are refused; table changes only through tbl_we_i
                    func_ok_reg  <= (rx_data_i == BSR_FUNC_READ);
                    body_cnt_reg <= 3'd0;
                    state_reg    <= BSR_RX_BODY;
                end
                BSR_RX_BODY: if (rx_valid_i) begin
                    crc_reg <= bsr_crc_byte(crc_reg, rx_data_i);
                    unique case (body_cnt_reg)
                        3'd0:    start_reg[15:8] <= rx_data_i;
                        3'd1:    start_reg[7:0]  <= rx_data_i;
                        3'd2:    count_reg[15:8] <= rx_data_i;
                        default: count_reg[7:0]  <= rx_data_i;
                    endcase
                    body_cnt_reg <= body_cnt_reg + 3'd1;
                    if (body_cnt_reg == 3'd3) begin
                        state_reg    <= BSR_RX_CRC;
                        crc_half_reg <= 1'b0;
                    end
                end
                BSR_RX_CRC: if (rx_valid_i) begin
                    crc_half_reg <= 1'b1;
                    crc_lo_reg   <= rx_data_i;
                    if (crc_half_reg) begin
                        // crc travels low byte first on the wire
                        if ({rx_data_i, crc_lo_reg} == crc_reg) begin
                            state_reg    <= BSR_TX_HEAD;
                            head_idx_reg <= 3'd0;
                            crc_reg      <= BSR_CRC_INIT;
                            if (!func_ok_reg) begin
                                exc_reg <= BSR_EXC_FUNC;
                            end else if (count_reg == 16'h0000
                                         || count_reg > {8'h00, BSR_TABLE_LEN}) begin
                                exc_reg <= BSR_EXC_COUNT;
                            end else if (start_reg < BSR_ADDR_VALIDITY
                                         || {1'b0, start_reg} + {1'b0, count_reg}
                                            > {1'b0, BSR_ADDR_VALIDITY}
                                              + {9'h000, BSR_TABLE_LEN}) begin
                                exc_reg <= BSR_EXC_ADDR;
                            end else begin
                                exc_reg <= 8'h00;
                            end
                        end else begin
                            state_reg <= BSR_RX_SKIP;
                        end
                    end
                end
                BSR_TX_HEAD: if (!tx_valid_o || tx_fire) begin
                    tx_valid_o   <= 1'b1;
                    tx_last_o    <= 1'b0;
                    tx_data_o    <= head_byte(head_idx_reg, func_reg, exc_reg,
                                              slave_addr_i, count_reg);
                    crc_reg      <= bsr_crc_byte(crc_reg, head_byte(head_idx_reg,
                                     func_reg, exc_reg, slave_addr_i, count_reg));
                    head_idx_reg <= head_idx_reg + 3'd1;
                    word_idx_reg <= 8'h00;
                    half_reg     <= 1'b0;
                    crc_half_reg <= 1'b0;
                    if (head_idx_reg == 3'd2) begin
                        state_reg <= (exc_reg != 8'h00) ? BSR_TX_CRC : BSR_TX_DATA;
                    end
                end
                BSR_TX_DATA: if (tx_fire) begin
                    // high byte first; low byte kept so the memory can run ahead
                    tx_data_o   <= half_reg ? lo_byte_reg : cur_word[15:8];
                    crc_reg     <= bsr_crc_byte(crc_reg,
                                    half_reg ? lo_byte_reg : cur_word[15:8]);
                    lo_byte_reg <= cur_word[7:0];
                    half_reg    <= ~half_reg;
                    if (half_reg) begin
                        word_idx_reg <= word_idx_reg + 8'h01;
                        if ({8'h00, word_idx_reg} + 16'h0001 == count_reg) begin
                            state_reg <= BSR_TX_CRC;
                        end
                    end
                end
                BSR_TX_CRC: if (tx_fire) begin
                    crc_half_reg <= 1'b1;
                    tx_data_o    <= crc_half_reg ? crc_reg[15:8] : crc_reg[7:0];
                    tx_last_o    <= crc_half_reg;
                    if (crc_half_reg) begin
                        state_reg <= BSR_RX_SKIP;
                    end
                end
                BSR_RX_SKIP: begin
                    if (tx_fire) begin
                        tx_valid_o <= 1'b0;
                        tx_last_o  <= 1'b0;
                    end
                    if (frame_end_i && !tx_valid_o) begin
                        state_reg <= BSR_RX_ADDR;
                    end
                end
                default: state_reg <= BSR_RX_ADDR;
            endcase
            // a request cut short by the line gap restarts the parser
            if (frame_end_i && (state_reg == BSR_RX_FUNC || state_reg == BSR_RX_BODY
                                || state_reg == BSR_RX_CRC)) begin
                state_reg <= BSR_RX_ADDR;
            end
        end
    end
endmodule
`default_nettype wire

/* File: core/bsr_table_mem.sv */
// Purpose: 113-word table store for the breaker readout
// Assumes: filled by device-side logic, read by the reply sequencer
// Notes: registered read data, one cycle latency
`default_nettype none
module bsr_table_mem
    import bsr_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        we_i,
    input  wire logic [6:0]  waddr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic [6:0]  raddr_i,
    output logic      [15:0] rdata_o
);
    logic [15:0] mem [0:112];

    always_ff @(posedge clk_i) begin
        if (we_i && waddr_i <= BSR_TABLE_MAX_IDX) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge clk_i) begin
        rdata_o <= (raddr_i <= BSR_TABLE_MAX_IDX) ? mem[raddr_i] : BSR_RESET_WORD;
    end
endmodule
`default_nettype wire

/* File: pkg/bsr_pkg.sv */
// Purpose: constants for the breaker status readout slave
// Assumes: bytes arrive already deframed from the serial line, one strobe each
// Notes: Operation list follows
//
// Operation
// - 32-bit values sent upper register first
// - reply echoes, byte count, data high first
// - frame address equals register number minus one
// - whole 113-register table in one read
// - validity word flags each status bit; the code flags bits 0-3, 5 and 6 but not bit 15
// - bit 0 set when contacts closed
// - bit 1 set on any trip
// - bit 2 set on electrical fault trip
// - bit 3 spring charged, zero if absent
// - bit 5 ready to close, zero if absent
// - bit 15 marks data unavailable
// - read-only registers ignore writes
`default_nettype none
package bsr_pkg;
    localparam logic [7:0]  BSR_FUNC_READ      = 8'h03;
    localparam logic [15:0] BSR_ADDR_VALIDITY  = 16'h2EDF;
    localparam logic [15:0] BSR_ADDR_STATUS    = 16'h2EE0;
    localparam logic [7:0]  BSR_TABLE_LEN      = 8'h71;
    localparam logic [6:0]  BSR_TABLE_MAX_IDX  = 7'h70;
    localparam logic [7:0]  BSR_SLAVE_ADDR_DEF = 8'h01;
    localparam logic [15:0] BSR_CRC_INIT       = 16'hFFFF;
    localparam logic [15:0] BSR_CRC_POLY       = 16'hA001;
    localparam logic [7:0]  BSR_EXC_FLAG       = 8'h80;
    localparam logic [7:0]  BSR_EXC_FUNC       = 8'h01;
    localparam logic [7:0]  BSR_EXC_ADDR       = 8'h02;
    localparam logic [7:0]  BSR_EXC_COUNT      = 8'h03;
    localparam int          BSR_BIT_CLOSED     = 0;
    localparam int          BSR_BIT_TRIP       = 1;
    localparam int          BSR_BIT_FAULT      = 2;
    localparam int          BSR_BIT_SPRING     = 3;
    localparam int          BSR_BIT_READY      = 5;
    localparam int          BSR_BIT_VARIANT    = 6;
    localparam int          BSR_BIT_UNAVAIL    = 15;
    localparam logic [15:0] BSR_STATUS_IMPL    = 16'h806F;
    localparam logic [15:0] BSR_RESET_WORD     = 16'h0000;

    typedef enum logic [2:0] {
        BSR_RX_ADDR  = 3'b000,
        BSR_RX_FUNC  = 3'b001,
        BSR_RX_BODY  = 3'b011,
        BSR_RX_CRC   = 3'b010,
        BSR_TX_HEAD  = 3'b110,
        BSR_TX_DATA  = 3'b111,
        BSR_TX_CRC   = 3'b101,
        BSR_RX_SKIP  = 3'b100
    } bsr_state_t;

    function automatic logic [15:0] bsr_crc_byte(input logic [15:0] crc,
                                                 input logic [7:0]  data);
        logic [15:0] c;
        c = crc ^ {8'h00, data};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ BSR_CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction
endpackage
`default_nettype wire

/* File: sim/breaker_status_register_readout_tb_top.sv */
// Purpose: self-checking bench for the breaker readout slave
// Assumes: station address fixed, master model drives the request side
// Notes: status pins settle within four cycles of a change
`default_nettype none
module breaker_status_register_readout_tb_top
    import bsr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] SA = 8'h2F;
    logic        clk_i, rst_i, rx_valid, rx_fe, tx_valid, tx_ready, tx_last, tbl_we, busy;
    logic [7:0]  rx_data, tx_data;
    logic [8:0]  pin = 9'h000;
    logic [6:0]  tbl_waddr = 7'h00;
    logic [15:0] tbl_wdata = 16'h0000;
    int          fails = 0, checks = 0, cyc = 0;
    bsr_readout i_bsr_readout (
        .clk_i(clk_i), .rst_i(rst_i), .slave_addr_i(SA), .rx_valid_i(rx_valid),
        .rx_data_i(rx_data), .frame_end_i(rx_fe), .tx_valid_o(tx_valid),
        .tx_data_o(tx_data), .tx_ready_i(tx_ready), .tx_last_o(tx_last),
        .contacts_closed_i(pin[0]), .any_trip_flag_i(pin[1]), .fault_trip_flag_i(pin[2]),
        .spring_charged_i(pin[3]), .ready_to_close_i(pin[4]), .has_spring_i(pin[5]),
        .has_ready_contact_i(pin[6]), .variant_flag_i(pin[7]), .data_valid_i(pin[8]),
        .tbl_we_i(tbl_we), .tbl_waddr_i(tbl_waddr), .tbl_wdata_i(tbl_wdata), .busy_o(busy));
    bsr_master i_bsr_master (
        .clk_i(clk_i), .rx_valid_o(rx_valid), .rx_data_o(rx_data), .frame_end_o(rx_fe),
        .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_last_i(tx_last), .tx_ready_o(tx_ready));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] rg(input int i);
        return {i_bsr_master.rsp[3 + 2 * i], i_bsr_master.rsp[4 + 2 * i]};
    endfunction
    function automatic logic [15:0] pat(input int i);
        return i == 52 ? 16'hFFF2 : i == 53 ? 16'hA96E : {i[7:0], 8'h5A};
    endfunction
    task automatic check(input logic [15:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic frame(input logic [7:0] fn, b2, input int len);
        logic [7:0] r [$];
        r = i_bsr_master.rsp;
        check(16'(r.size()), 16'(len));
        check({r[0], r[1]}, {SA, fn});
        check({8'h00, r[2]}, {8'h00, b2});
        check(i_bsr_master.crc16(r), 16'h0000);
        check({15'h0000, busy}, 16'h0000);
    endtask
    task automatic t_status;
        logic [8:0]  pv [3] = '{9'h1FB, 9'h11E, 9'h01E};
        logic [15:0] ev [3] = '{16'h006F, 16'h006F, 16'h0000};
        logic [15:0] es [3] = '{16'h006B, 16'h0006, 16'h8000};
        logic [15:0] em [3] = '{16'hFFFF, 16'hFFFF, 16'h8000};
        for (int k = 0; k < 3; k++) begin
            @(posedge clk_i);
            pin <= pv[k];
            repeat (4) @(posedge clk_i);
            i_bsr_master.xfer(SA, BSR_FUNC_READ, BSR_ADDR_VALIDITY, 16'h0002, 1'b0, k[0]);
            frame(BSR_FUNC_READ, 8'h04, 9);
            check(rg(0), ev[k]);
            check(rg(1) & em[k], es[k]);
        end
    endtask
    task automatic t_table;
        @(posedge clk_i);
        pin <= 9'h1FB;
        // live words must win over table writes at index 0 and 1
        for (int i = 0; i < 113; i++) begin
            @(posedge clk_i);
            tbl_we    <= 1'b1;
            tbl_waddr <= 7'(i);
            tbl_wdata <= i < 2 ? 16'hFFFF : pat(i);
        end
        @(posedge clk_i);
        tbl_we <= 1'b0;
        i_bsr_master.xfer(SA, BSR_FUNC_READ, BSR_ADDR_VALIDITY, 16'(BSR_TABLE_LEN), 1'b0, 1'b1);
        frame(BSR_FUNC_READ, 8'hE2, 231);
        check(rg(0), 16'h006F);
        check(rg(1), 16'h006B);
        for (int i = 2; i < 113; i++) check(rg(i), pat(i));
        check(16'($signed({rg(52), rg(53)}) == -874130), 16'h0001);
    endtask
    task automatic t_errors;
        // station, function, start, count, bad crc, reply length, third byte
        logic [63:0] cs [9] = '{64'h30032EDF00010000, 64'h2F032EDF00011000,
            64'h2F062EE012340501, 64'h2F042EDF00010501, 64'h2F032EDF00000503,
            64'h2F032EDF00720503, 64'h2F032EDE00010502, 64'h2F032F4F00020502,
            64'h2F032EE000010702};
        logic [63:0] c;
        for (int k = 0; k < 9; k++) begin
            c = cs[k];
            i_bsr_master.xfer(c[63:56], c[55:48], c[47:32], c[31:16], c[12], 1'b0);
            if (c[11:8] == 4'h0) check(16'(i_bsr_master.rsp.size()), 16'h0000);
            else frame(c[11:8] == 4'h7 ? c[55:48] : c[55:48] | BSR_EXC_FLAG, c[7:0],
                       int'(c[11:8]));
        end
        check(rg(0), 16'h006B);
    endtask
    task automatic wrap_up;
        if (fails == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    // generous ceiling: the whole run needs under two thousand cycles
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 6000) begin
            fails++;
            wrap_up();
        end
    end
    initial begin
        rst_i  = 1'b1;
        tbl_we = 1'b0;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        t_status();
        t_table();
        t_errors();
        wrap_up();
    end
endmodule
`default_nettype wire

/* File: sim/bsr_assertions.sv */
// Purpose: port checks for the breaker readout slave
// Assumes: bound to bsr_readout, one clock domain
// Notes: request fields captured from the byte stream
`default_nettype none
module bsr_readout_checker
    import bsr_pkg::*;
(
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic [7:0] slave_addr_i,
    input wire logic       rx_valid_i,
    input wire logic [7:0] rx_data_i,
    input wire logic       frame_end_i,
    input wire logic       tx_valid_o,
    input wire logic [7:0] tx_data_o,
    input wire logic       tx_ready_i,
    input wire logic       tx_last_o,
    input wire logic       busy_o
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [15:0] END_ADDR = BSR_ADDR_VALIDITY + 16'(BSR_TABLE_LEN);
    logic [7:0]  rq [8];
    logic [3:0]  rx_idx;
    logic [7:0]  tx_cnt;
    logic [15:0] st;
    logic [15:0] cn;
    logic        ok;
    assign st = {rq[2], rq[3]};
    assign cn = {rq[4], rq[5]};
    // a read that must be served rather than refused
    assign ok = rq[1] == BSR_FUNC_READ && cn != 16'h0000 && cn <= 16'(BSR_TABLE_LEN)
                && st >= BSR_ADDR_VALIDITY && {1'b0, st} + {1'b0, cn} <= {1'b0, END_ADDR};
    always_ff @(posedge clk_i) begin
        if (rst_i || frame_end_i) begin
            rx_idx <= 4'h0;
        end else if (rx_valid_i && rx_idx < 4'h8) begin
            rq[rx_idx[2:0]] <= rx_data_i;
            rx_idx          <= rx_idx + 4'h1;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_cnt <= 8'h00;
        end else if (tx_valid_o && tx_ready_i) begin
            tx_cnt <= tx_last_o ? 8'h00 : tx_cnt + 8'h01;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_hold_byte: assert property (
        tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o) && $stable(tx_last_o))
        else $error("reply byte changed before taken");
    a_last_valid: assert property (tx_last_o |-> tx_valid_o && busy_o)
        else $error("last flag without valid byte");
    a_reset_quiet: assert property ($fell(rst_i) |-> !tx_valid_o && !tx_last_o)
        else $error("reply active after reset");
    a_echo_addr: assert property (
        tx_valid_o && tx_cnt == 8'h00 |-> tx_data_o == slave_addr_i)
        else $error("first reply byte not station address");
    a_echo_func: assert property (
        tx_valid_o && tx_cnt == 8'h01 |-> tx_data_o == (ok ? BSR_FUNC_READ : rq[1] | BSR_EXC_FLAG))
        else $error("function byte wrong");
    a_byte_count: assert property (
        tx_valid_o && tx_cnt == 8'h02 && ok |-> tx_data_o == 8'(cn << 1))
        else $error("byte count wrong");
    a_last_place: assert property (
        tx_last_o && tx_valid_o |-> tx_cnt == (ok ? 8'(2 * cn + 4) : 8'h04))
        else $error("reply length wrong");
    a_reply_cause: assert property (
        $rose(tx_valid_o) |-> rx_idx == 4'h8 && ($past(rx_valid_i) || $past(rx_valid_i, 2)))
        else $error("reply without full request");
endmodule
bind bsr_readout bsr_readout_checker i_bsr_readout_checker (
    .clk_i, .rst_i, .slave_addr_i, .rx_valid_i, .rx_data_i, .frame_end_i,
    .tx_valid_o, .tx_data_o, .tx_ready_i, .tx_last_o, .busy_o
);
`default_nettype wire

/* File: sim/bsr_master.sv */
// Purpose: remote master issuing read requests and taking replies
// Assumes: one byte pulse every other cycle
// Notes: slow mode stalls the reply sink half the time
`default_nettype none
module bsr_master
    import bsr_pkg::*;
(
    input  wire logic       clk_i,
    output logic            rx_valid_o,
    output logic      [7:0] rx_data_o,
    output logic            frame_end_o,
    input  wire logic       tx_valid_i,
    input  wire logic [7:0] tx_data_i,
    input  wire logic       tx_last_i,
    output logic            tx_ready_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rsp [$];
    initial begin
        rx_valid_o  = 1'b0;
        rx_data_o   = 8'h00;
        frame_end_o = 1'b0;
        tx_ready_o  = 1'b1;
    end
    function automatic logic [15:0] crc16(input logic [7:0] b [$]);
        logic [15:0] c;
        c = BSR_CRC_INIT;
        foreach (b[i]) begin
            c = c ^ {8'h00, b[i]};
            for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ BSR_CRC_POLY : c >> 1;
        end
        return c;
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    task automatic xfer(input logic [7:0] sa, fn, input logic [15:0] st, cn,
                        input logic bad, slow);
        logic [7:0]  q [$];
        logic [15:0] c;
        logic        done;
        int          w;
        q = {sa, fn, st[15:8], st[7:0], cn[15:8], cn[7:0]};
        c = crc16(q);
        q.push_back(c[7:0] ^ {7'h00, bad});
        q.push_back(c[15:8]);
        rsp.delete();
        foreach (q[i]) begin
            @(posedge clk_i);
            rx_valid_o <= 1'b1;
            rx_data_o  <= q[i];
            @(posedge clk_i);
            rx_valid_o <= 1'b0;
            // released line shows the inverse, not a stale byte
            rx_data_o  <= ~q[i];
        end
        done = 1'b0;
        for (w = 0; w < 1000 && !done; w++) begin
            @(posedge clk_i);
            if (tx_valid_i && tx_ready_o) begin
                rsp.push_back(tx_data_i);
                done = tx_last_i;
            end
            tx_ready_o <= !slow || w[1];
            if (rsp.size() == 0 && w > 30) break;
        end
        @(posedge clk_i);
        tx_ready_o  <= 1'b1;
        frame_end_o <= 1'b1;
        @(posedge clk_i);
        frame_end_o <= 1'b0;
    endtask
endmodule
`default_nettype wire
